// file: hw/csp_dev_end.sv
/*
 * csp_dev_end: crc checked serial slave port with readback, streaming,
 * auto echo and latched alert flags.
 * assumes sclk idles high and pins pass two sync flops, so a serial
 * half period spans at least four sys_clk cycles.
 */
module csp_dev_end (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    csp_link_if.dev link,
    input wire logic [3:0] din_comp,
    input wire logic conv_ready,
    output logic alert_n,
    output logic wr_strobe,
    output logic [csp_pkg::IDX_W-1:0] wr_index,
    output logic [csp_pkg::DATA_W-1:0] wr_data
);
    import csp_pkg::*;

    typedef struct packed {
        logic [2:0] sclk_s;
        logic [2:0] cs_s;
        logic [1:0] sdi_s;
        logic [31:0] in_sr;
        logic [31:0] out_sr;
        logic [5:0] fe_cnt;
        logic [5:0] re_cnt;
        logic [4:0] sub_cnt;
        logic half_bit;
        logic rb_frame;
        logic rb_pend;
        logic [6:0] ptr_idx;
        logic info_sel;
        logic echo_en;
        logic [6:0] strm_idx;
        logic [1:0] status;
        logic [1:0] mask;
        logic [REG_COUNT-1:0][15:0] mem;
        logic sdo;
        logic sdo_oe;
        logic alert_n;
        logic wr_strobe;
        logic [6:0] wr_index;
        logic [15:0] wr_data;
    } csp_dev_state_t;

    csp_dev_state_t q;
    csp_dev_state_t d;

    // every output is a flop of the state record
    assign link.sdo = q.sdo;
    assign link.sdo_oe = q.sdo_oe;
    assign alert_n = q.alert_n;
    assign wr_strobe = q.wr_strobe;
    assign wr_index = q.wr_index;
    assign wr_data = q.wr_data;

    // register read decode, used by every readback and streamed word
    function automatic logic [15:0] rd_reg(input logic [6:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        unique case (idx)
            IDX_RB_PTR: begin
                v[6:0] = q.ptr_idx;
                v[PTR_INFO_BIT] = q.info_sel;
                v[PTR_ECHO_BIT] = q.echo_en;
            end
            IDX_ALERT_ST: v[1:0] = q.status;
            IDX_ALERT_MASK: v[1:0] = q.mask;
            default: v = q.mem[idx];
        endcase
        return v;
    endfunction

    // build one outgoing 32-bit word for a register index
    function automatic logic [31:0] frame_word(input logic [6:0] idx);
        logic [6:0] hdr;
        logic [23:0] upper;
        if (q.info_sel) begin
            hdr = {1'b0, |(q.status & ~q.mask), conv_ready, din_comp};
        end else begin
            hdr = idx;
        end
        upper = {1'b1, hdr, rd_reg(idx)};
        return {upper, crc8(upper)};
    endfunction

    logic sclk_fall;
    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;
    logic active;
    logic long_frame;
    logic len_ok;
    logic crc_ok;
    logic [6:0] w_idx;
    logic [15:0] w_dat;

    // edges are found between the second and third sync flops only
    assign sclk_fall = q.sclk_s[2] & ~q.sclk_s[1];
    assign sclk_rise = ~q.sclk_s[2] & q.sclk_s[1];
    assign cs_fall = q.cs_s[2] & ~q.cs_s[1];
    assign cs_rise = ~q.cs_s[2] & q.cs_s[1];
    assign active = ~q.cs_s[1];

    // frame checks evaluated when select returns high
    assign long_frame = q.fe_cnt > CNT_FRAME;
    assign w_idx = q.in_sr[IDX_HI:IDX_LO];
    assign w_dat = q.in_sr[DAT_HI:DAT_LO];
    assign crc_ok = crc8(q.in_sr[31:DAT_LO]) == q.in_sr[CRC_HI:0];
    always_comb begin
        if (long_frame) begin
            // streamed read: whole 24-bit words after the first 32 bits
            len_ok = q.rb_frame && q.sub_cnt == 5'h00 && !q.half_bit;
        end else begin
            len_ok = q.fe_cnt == CNT_FRAME && q.re_cnt == CNT_FRAME;
        end
    end

    // next state
    always_comb begin
        logic [31:0] nxt_word;
        logic [6:0] nxt_idx;
        nxt_word = 32'h0000_0000;
        nxt_idx = q.strm_idx + 7'h01;
        d = q;
        d.wr_strobe = 1'b0;
        d.sclk_s = {q.sclk_s[1:0], link.sclk};
        d.cs_s = {q.cs_s[1:0], link.cs_n};
        d.sdi_s = {q.sdi_s[0], link.sdi};

        if (cs_fall) begin
            // readback due after a pointer write, or with echo on
            d.fe_cnt = 6'h00;
            d.re_cnt = 6'h00;
            d.sub_cnt = 5'h00;
            d.half_bit = 1'b0;
            d.rb_frame = q.rb_pend | q.echo_en;
            d.strm_idx = q.ptr_idx;
            if (q.rb_pend | q.echo_en) begin
                d.out_sr = frame_word(q.ptr_idx);
            end else begin
                d.out_sr = OUT_IDLE_WORD;
            end
            d.sdo_oe = 1'b1;
        end else if (active) begin
            if (sclk_fall) begin
                d.in_sr = {q.in_sr[30:0], q.sdi_s[1]};
                d.half_bit = 1'b1;
                if (q.fe_cnt != 6'h3F) begin
                    d.fe_cnt = q.fe_cnt + 6'h01;
                end
            end
            if (sclk_rise) begin
                d.half_bit = 1'b0;
                if (q.re_cnt != 6'h3F) begin
                    d.re_cnt = q.re_cnt + 6'h01;
                end
                if (q.re_cnt == CNT_LAST || (q.re_cnt > CNT_LAST && q.sub_cnt == STREAM_LAST)) begin
                    // word boundary: readback continues at next index
                    d.sub_cnt = 5'h00;
                    if (q.rb_frame) begin
                        nxt_word = frame_word(nxt_idx);
                        d.strm_idx = nxt_idx;
                        d.out_sr = {nxt_word[23:0], 8'h00};
                    end else begin
                        d.out_sr = {q.out_sr[30:0], 1'b0};
                    end
                end else begin
                    d.out_sr = {q.out_sr[30:0], 1'b0};
                    if (q.re_cnt > CNT_LAST) begin
                        d.sub_cnt = q.sub_cnt + 5'h01;
                    end
                end
            end
        end

        if (cs_rise) begin
            // nothing is stored before the whole frame has been checked
            d.sdo_oe = 1'b0;
            d.rb_pend = 1'b0;
            if (!len_ok) begin
                d.status[ST_CNT_BIT] = 1'b1;
            end else if (long_frame) begin
                // streamed frames never write
                d.rb_pend = 1'b0;
            end else if (!crc_ok) begin
                d.status[ST_CRC_BIT] = 1'b1;
            end else begin
                unique case (w_idx)
                    IDX_IDLE_CMD: d.rb_pend = 1'b0;
                    IDX_RB_PTR: begin
                        d.ptr_idx = w_dat[6:0];
                        d.info_sel = w_dat[PTR_INFO_BIT];
                        d.echo_en = w_dat[PTR_ECHO_BIT];
                        d.rb_pend = 1'b1;
                    end
                    IDX_ALERT_ST: d.status = q.status & ~w_dat[1:0];
                    IDX_ALERT_MASK: d.mask = w_dat[1:0];
                    default: begin
                        d.mem[w_idx] = w_dat;
                        d.wr_strobe = 1'b1;
                        d.wr_index = w_idx;
                        d.wr_data = w_dat;
                    end
                endcase
            end
        end

        // line is driven only inside a frame
        d.sdo = d.sdo_oe & d.out_sr[31];
        d.alert_n = ~|(d.status & ~d.mask);
    end

    // state register; alert and select idle high out of reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.sclk_s <= 3'h7;
            q.cs_s <= 3'h7;
            q.alert_n <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule

// file: hw/csp_pkg.sv
/*
 * csp_pkg: constants, field positions and the crc function for both ends.
 * assumes both ends run on one 125 MHz sys_clk and include this package.
 */
// Operation
// - shift 32 bits in, msb first, falling edges
// - frame: reserved, 7-bit index, data, crc
// - master appends crc8 over 24 bits
// - master sends 32 bits before raising select
// - good crc writes; bad crc flags, alert
// - write one clears crc flag; maskable
// - exactly 32 falling edges, else flag
// - read: pointer write, then data frame
// - bit 31 one; rest on rising edges
// - info select low: index, data, crc
// - info select high: zero, alert, ready, comparators
// - held select streams next indices
// - stream length 32 plus n times 24
// - no register writes while streaming
// - auto echo returns selected register
// - auto echo rereads pointer after select rises
// - alert low while unmasked flag set
package csp_pkg;
    // frame geometry
    localparam int FRAME_BITS = 32;
    localparam int IDX_W = 7;
    localparam int DATA_W = 16;
    localparam int IDX_HI = 30;
    localparam int IDX_LO = 24;
    localparam int DAT_HI = 23;
    localparam int DAT_LO = 8;
    localparam int CRC_HI = 7;
    localparam int REG_COUNT = 128;
    localparam logic [5:0] CNT_FRAME = 6'h20;
    localparam logic [5:0] CNT_LAST = 6'h1F;
    localparam logic [4:0] STREAM_LAST = 5'h17;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [31:0] OUT_IDLE_WORD = 32'h8000_0000;

    // register indices held by the port itself
    localparam logic [6:0] IDX_IDLE_CMD = 7'h00;
    localparam logic [6:0] IDX_RB_PTR = 7'h6E;
    localparam logic [6:0] IDX_ALERT_ST = 7'h2E;
    localparam logic [6:0] IDX_ALERT_MASK = 7'h2F;
    localparam int PTR_INFO_BIT = 7;
    localparam int PTR_ECHO_BIT = 8;
    localparam int ST_CRC_BIT = 0;
    localparam int ST_CNT_BIT = 1;

    // master side: command word fields and bus map
    localparam int CMD_W = 27;
    localparam int CMD_N_HI = 26;
    localparam int CMD_N_LO = 23;
    localparam int CMD_IDX_HI = 22;
    localparam int CMD_IDX_LO = 16;
    localparam int FIFO_DEPTH = 32;
    localparam logic [4:0] AV_CMD = 5'h00;
    localparam logic [4:0] AV_STATUS = 5'h04;
    localparam logic [4:0] AV_RXWORD = 5'h08;
    localparam logic [4:0] AV_STREAM = 5'h0C;
    localparam logic [8:0] BITS_FRAME = 9'h020;
    localparam logic [8:0] BITS_STREAM = 9'h018;

    // serial clock timing
    localparam int SYS_CLK_NS = 8;
    localparam int SCLK_HALF_NS = 64;
    localparam logic [3:0] SCLK_HALF_CYC = 4'(SCLK_HALF_NS / SYS_CLK_NS);

    // crc8, msb first, zero seed; both ends use it
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        logic fb;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction
endpackage

// file: hw/csp_link_if.sv
/*
 * csp_link_if: the four serial wires between master and slave port.
 * assumes a pull-up on the data-out line; resolved here from the enable.
 */
interface csp_link_if;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic sdo_wire;

    // released line floats high through the pull-up
    assign sdo_wire = sdo_oe ? sdo : 1'b1;

    modport dev (input sclk, input cs_n, input sdi, output sdo, output sdo_oe);
    modport host (output sclk, output cs_n, output sdi, input sdo_wire);
endinterface

// file: hw/csp_fifo.sv
/*
 * csp_fifo: synchronous valid/ready fifo, width and depth as parameters.
 * assumes depth is a power of two and a single sys_clk domain.
 */
module csp_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } csp_fifo_state_t;

    csp_fifo_state_t q;
    csp_fifo_state_t d;
    logic push;
    logic pop;

    // flags come from the registered count, so no path from ready to valid
    assign in_ready = q.cnt != (AW + 1)'(DEPTH);
    assign out_valid = q.cnt != '0;
    assign out_data = q.mem[q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // next state
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp = q.wp + AW'(1);
        end
        if (pop) begin
            d.rp = q.rp + AW'(1);
        end
        if (push && !pop) begin
            d.cnt = q.cnt + (AW + 1)'(1);
        end else if (pop && !push) begin
            d.cnt = q.cnt - (AW + 1)'(1);
        end
    end

    // state register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule

// file: hw/csp_host_end.sv
/*
 * csp_host_end: serial master that runs the slave port; commands are
 * queued over an avalon-mm slave and sent as crc protected frames.
 * assumes avalon masters hold a request until waitrequest is seen low.
 */
module csp_host_end (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    csp_link_if.host link,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import csp_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_HIGH, H_LOW, H_TAIL, H_GAP} csp_host_st_t;

    typedef struct packed {
        csp_host_st_t state;
        logic [1:0] sdo_s;
        logic [3:0] cnt;
        logic [31:0] tx;
        logic [31:0] rx;
        logic [31:0] first;
        logic [23:0] strm;
        logic [8:0] sent;
        logic [8:0] total;
        logic [7:0] frames;
        logic sclk;
        logic cs_n;
        logic sdi;
        logic waitreq;
        logic [31:0] rdata;
    } csp_host_state_t;

    csp_host_state_t q;
    csp_host_state_t d;
    logic fifo_push;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [CMD_W-1:0] fifo_out_data;

    assign link.sclk = q.sclk;
    assign link.cs_n = q.cs_n;
    assign link.sdi = q.sdi;
    assign avs_readdata = q.rdata;
    assign avs_waitrequest = q.waitreq;
    assign fifo_pop = q.state == H_IDLE;

    // full queue holds waitrequest high, stalling the bus master
    csp_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(avs_writedata[CMD_W-1:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // status and received words for the bus
    function automatic logic [31:0] rd_host(input logic [4:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            AV_STATUS: begin
                v[0] = q.state != H_IDLE || fifo_out_valid;
                v[1] = !fifo_out_valid;
                v[2] = q.first[31] && crc8(q.first[31:8]) == q.first[7:0];
                v[15:8] = q.frames;
            end
            AV_RXWORD: v = q.first;
            AV_STREAM: v = {8'h00, q.strm};
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // next state
    always_comb begin
        logic [23:0] hdr;
        logic [31:0] rx_n;
        hdr = {1'b0, fifo_out_data[CMD_IDX_HI:CMD_IDX_LO], fifo_out_data[15:0]};
        rx_n = {q.rx[30:0], q.sdo_s[1]};
        d = q;
        fifo_push = 1'b0;
        d.sdo_s = {q.sdo_s[0], link.sdo_wire};

        // one answer per request, a cycle after it is seen and, for a command, the queue has room
        if ((avs_read || avs_write) && q.waitreq) begin
            if (avs_write && avs_address == AV_CMD) begin
                if (fifo_in_ready) begin
                    fifo_push = 1'b1;
                    d.waitreq = 1'b0;
                end
            end else begin
                d.waitreq = 1'b0;
                d.rdata = avs_read ? rd_host(avs_address) : 32'h0000_0000;
            end
        end else begin
            d.waitreq = 1'b1;
        end

        unique case (q.state)
            H_IDLE: begin
                if (fifo_out_valid) begin
                    d.tx = {hdr, crc8(hdr)};
                    d.total = BITS_FRAME + 9'(fifo_out_data[CMD_N_HI:CMD_N_LO]) * BITS_STREAM;
                    d.sent = 9'h000;
                    d.cnt = 4'h0;
                    d.cs_n = 1'b0;
                    d.sdi = hdr[23];
                    d.state = H_HIGH;
                end
            end
            H_HIGH: begin
                d.cnt = q.cnt + 4'h1;
                if (q.cnt == SCLK_HALF_CYC - 4'h1) begin
                    d.cnt = 4'h0;
                    d.sclk = 1'b0;
                    d.state = H_LOW;
                end
            end
            H_LOW: begin
                d.cnt = q.cnt + 4'h1;
                if (q.cnt == SCLK_HALF_CYC - 4'h1) begin
                    d.cnt = 4'h0;
                    d.rx = rx_n;
                    d.sent = q.sent + 9'h001;
                    if (q.sent + 9'h001 == BITS_FRAME) begin
                        d.first = rx_n;
                    end
                    // stream tail sends zeros, implying no write
                    d.tx = {q.tx[30:0], 1'b0};
                    d.sdi = q.tx[30];
                    d.sclk = 1'b1;
                    d.state = (q.sent + 9'h001 == q.total) ? H_TAIL : H_HIGH;
                end
            end
            H_TAIL: begin
                d.cnt = q.cnt + 4'h1;
                if (q.cnt == SCLK_HALF_CYC - 4'h1) begin
                    d.cnt = 4'h0;
                    d.cs_n = 1'b1;
                    d.sdi = 1'b0;
                    d.state = H_GAP;
                end
            end
            H_GAP: begin
                d.cnt = q.cnt + 4'h1;
                if (q.cnt == SCLK_HALF_CYC - 4'h1) begin
                    d.cnt = 4'h0;
                    d.strm = q.rx[23:0];
                    d.frames = q.frames + 8'h01;
                    d.state = H_IDLE;
                end
            end
        endcase
    end

    // state register; serial clock and select idle high
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.state <= H_IDLE;
            q.sdo_s <= 2'h3;
            q.sclk <= 1'b1;
            q.cs_n <= 1'b1;
            q.waitreq <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule

// file: bench/csp_link_assertions.sv
/*
 * csp_link_checker: concurrent checks on the serial link.
 * assumes one sys_clk domain, watching the first link only.
 */
module csp_link_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic sdo_wire,
    input wire logic alert_n,
    input wire logic wr_strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sclk_q;
    logic cs_q;
    logic [8:0] cnt_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // raw falling edges per frame; held past select rise
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b1;
            cs_q <= 1'b1;
            cnt_q <= 9'h000;
        end else begin
            sclk_q <= sclk;
            cs_q <= cs_n;
            if (cs_q && !cs_n) begin
                cnt_q <= 9'h000;
            end else if (!cs_n && sclk_q && !sclk) begin
                cnt_q <= cnt_q + 9'h001;
            end
        end
    end

    // link behaviour of both ends
    a_oe_released: assert property (cs_n [*6] |-> !sdo_oe)
        else $error("sdo driven outside a frame");
    a_msb_one: assert property ($fell(cs_n) |-> ##[1:6] (sdo_oe && sdo_wire))
        else $error("first output bit not one");
    a_oe_in_frame: assert property (!cs_n && !sclk |-> sdo_oe)
        else $error("sdo released inside a frame");
    a_sdo_held: assert property (!cs_n && $fell(sclk) |-> $stable(sdo) ##1 $stable(sdo))
        else $error("sdo moved near a falling edge");
    a_sdi_held: assert property ($fell(sclk) |-> $stable(sdi))
        else $error("sdi moved at a falling edge");
    a_sclk_idle: assert property (cs_n [*3] |-> sclk)
        else $error("serial clock low outside a frame");
    a_frame_len: assert property ($rose(cs_n) |-> (cnt_q == 9'd32)
        || ((cnt_q > 9'd32) && ((cnt_q - 9'd32) % 9'd24 == 9'd0)))
        else $error("frame length not 32 plus whole words");
    a_strobe_late: assert property (wr_strobe |-> cs_n && $past(cs_n))
        else $error("write before frame end");
    a_strobe_pulse: assert property (wr_strobe |=> !wr_strobe)
        else $error("write strobe longer than one cycle");
    a_stream_nowrite: assert property ($rose(cs_n) && (cnt_q > 9'd32) |-> !wr_strobe [*8])
        else $error("write from a streaming frame");
endmodule

// file: bench/crc_checked_serial_slave_readback_test.sv
/*
 * crc_checked_serial_slave_readback_test: host drives device over the link;
 * a second device faces a driver that breaks frames on purpose.
 * assumes the csp design files and link checker compile first.
 */
module crc_checked_serial_slave_readback_test;
    timeunit 1ns;
    timeprecision 100ps;
    import csp_pkg::*;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [3:0] din_comp = 4'h0;
    logic conv_ready = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic alert_n;
    logic wr_strobe;
    logic alert2_n;
    logic wr_strobe2;
    logic [6:0] wr_index;
    logic [15:0] wr_data;
    int n_mismatch = 0;
    int total_checks = 0;
    int seed = 32'hd1f504ad;
    int n_str2 = 0;
    int wait_n;
    logic [15:0] mem [128];
    logic [31:0] exp_q [$];
    logic [31:0] rd_q [$];

    csp_link_if link ();
    csp_link_if link2 ();
    csp_host_end u_csp_host_end (.sys_clk(sys_clk), .rst(rst), .ce(ce), .link(link),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    csp_dev_end u_csp_dev_end (.sys_clk(sys_clk), .rst(rst), .ce(ce), .link(link),
        .din_comp(din_comp), .conv_ready(conv_ready), .alert_n(alert_n),
        .wr_strobe(wr_strobe), .wr_index(wr_index), .wr_data(wr_data));
    csp_dev_end u_csp_dev_end_b (.sys_clk(sys_clk), .rst(rst), .ce(ce), .link(link2),
        .din_comp(din_comp), .conv_ready(conv_ready), .alert_n(alert2_n),
        .wr_strobe(wr_strobe2), .wr_index(), .wr_data());
    csp_link_checker u_csp_link_checker (.sys_clk(sys_clk), .rst(rst), .sclk(link.sclk),
        .cs_n(link.cs_n), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe),
        .sdo_wire(link.sdo_wire), .alert_n(alert_n), .wr_strobe(wr_strobe));

    always #4 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // scoreboard: oldest note against each first-link write and each read answer while a note waits
    always @(posedge sys_clk) begin
        if (wr_strobe === 1'b1) begin
            chk({9'h000, wr_index, wr_data}, exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFFFFFF);
        end
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rd_q.size() > 0) begin
            chk(avs_readdata, rd_q.pop_front());
        end
        if (wr_strobe2 === 1'b1) begin
            n_str2++;
        end
    end

    // one avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        wait_n = 0;
        do begin
            @(posedge sys_clk);
            wait_n++;
        end while (avs_waitrequest !== 1'b0 && wait_n < 2000);
        if (wait_n >= 2000) begin
            n_mismatch++;
            complete_run();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 32'h00000000);
    endtask

    task automatic cmd(input logic [3:0] n, input logic [6:0] i, input logic [15:0] d);
        bus(1'b1, AV_CMD, {5'h00, n, i, d});
    endtask

    task automatic wrr(input logic [6:0] i, input logic [15:0] d);
        mem[i] = d;
        exp_q.push_back({9'h000, i, d});
        cmd(4'h0, i, d);
    endtask

    // polls status until the engine is idle and the queue is empty
    task automatic wait_idle();
        for (int k = 0; k < 20000; k++) begin
            bus(1'b0, AV_STATUS, 32'h00000000);
            if (avs_readdata[1:0] === 2'b10) return;
        end
        n_mismatch++;
        complete_run();
    endtask

    // bench's own check byte, msb first, zero seed
    function automatic logic [7:0] ref_crc(input logic [23:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction

    function automatic logic [31:0] rword(input logic [6:0] i, input logic info);
        logic [23:0] t;
        t = {1'b1, info ? {1'b0, ~alert_n, conv_ready, din_comp} : i, mem[i]};
        return {t, ref_crc(t)};
    endfunction

    function automatic logic [31:0] fw(input logic [6:0] i, input logic [15:0] d, input logic ok);
        return {1'b0, i, d, ref_crc({1'b0, i, d}) ^ (ok ? 8'h00 : 8'hFF)};
    endfunction

    // rule-breaking master on link2; 125 ns clock, free of sys_clk
    task automatic raw(input logic [31:0] w, input int nb);
        link2.cs_n = 1'b0;
        for (int i = 31; i > 31 - nb; i--) begin
            link2.sdi = w[i];
            #62.5 link2.sclk = 1'b0;
            #62.5 link2.sclk = 1'b1;
        end
        #62.5 link2.cs_n = 1'b1;
        link2.sdi = ~link2.sdi;
        #250;
    endtask

    initial begin
        logic [31:0] w;
        link2.sclk = 1'b1;
        link2.cs_n = 1'b1;
        link2.sdi = 1'b0;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        din_comp <= 4'($random(seed));
        conv_ready <= 1'b1;
        @(posedge sys_clk);
        chk({alert_n, wr_strobe, avs_waitrequest}, 32'h5);
        // overfill the queue so the last write stalls
        for (int i = 0; i < 34; i++) begin
            wrr(7'(i + 1), 16'($random(seed)));
        end
        chk(32'(wait_n > 2), 32'h1);
        wait_idle();
        chk(exp_q.size(), 32'h0);
        $display("test fill done");
        // plain, info and echo readback; second frame writes
        for (int m = 0; m < 3; m++) begin
            cmd(4'h0, IDX_RB_PTR, {7'h00, m == 2, m == 1, 7'(m + 5)});
            wrr(7'(m + 40), 16'($random(seed)));
            if (m == 2) cmd(4'h0, IDX_IDLE_CMD, 16'h0000);
            wait_idle();
            rd(AV_RXWORD, rword(7'(m + 5), m == 1));
        end
        $display("test readback done");
        // echo off; next frame streams two more words
        cmd(4'h0, IDX_RB_PTR, 16'h0010);
        cmd(4'h2, 7'h03, 16'hA5A5);
        wait_idle();
        rd(AV_RXWORD, rword(7'h10, 1'b0));
        w = rword(7'h12, 1'b0);
        rd(AV_STREAM, {8'h00, w[23:0]});
        rd(5'h10, 32'h00000000);
        $display("test stream done");
        // faulty frames, flag clear, mask and one good write on the second link
        raw(fw(7'h09, 16'($random(seed)), 1'b0), 32);
        chk(alert2_n, 32'h0);
        raw(fw(IDX_ALERT_ST, 16'h0001, 1'b1), 32);
        chk(alert2_n, 32'h1);
        raw(fw(7'h09, 16'h1234, 1'b1), 31);
        chk(alert2_n, 32'h0);
        raw(fw(IDX_ALERT_MASK, 16'h0003, 1'b1), 32);
        chk(alert2_n, 32'h1);
        raw(fw(7'h09, 16'h1234, 1'b1), 32);
        chk(n_str2, 32'h1);
        $display("test faults done");
        complete_run();
    end
endmodule
